// ===== dpgl_pkg.sv
// shared constants for the dual port gpio block with led drive
package dpgl_pkg;
    localparam int PORT_W = 8;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // register indices; byte address is four times the index
    localparam logic [ADDR_W-1:0] IDX_FIRST_DATA = 8'h00;
    localparam logic [ADDR_W-1:0] IDX_SECOND_DATA = 8'h01;
    localparam logic [ADDR_W-1:0] IDX_FIRST_DIR = 8'h04;
    localparam logic [ADDR_W-1:0] IDX_SECOND_DIR = 8'h05;
    localparam logic [ADDR_W-1:0] IDX_FIRST_LED = 8'h0C;
    // reset values
    localparam logic [PORT_W-1:0] DIR_RESET = 8'h00;
    localparam logic [PORT_W-1:0] LED_RESET = 8'h00;
    // second port pin positions
    localparam int PIN_TW_DATA = 0;
    localparam int PIN_TW_CLOCK = 1;
    localparam int PIN_SER_TX = 2;
    localparam int PIN_SER_RX = 3;
    localparam int PIN_TIMER_LO = 4;
    localparam int OPEN_DRAIN_PINS = 4;
    localparam int TIMER_CHANNELS = 4;
    // edge/level select code that leaves a timer pin to the port
    localparam logic [1:0] ELS_PORT = 2'h0;
    // converter channel select codes 0..7 address first port pins
    localparam logic [4:0] CONV_LAST_PIN = 5'h07;
    localparam real LED_SINK_MA = 15.0;
endpackage

// ===== dpgl_port.sv
// dual 8-bit gpio ports with led drive and peripheral pin takeover
`timescale 1ns/1ps
// What this block does
// (RULE1) direction bit one enables pin output buffer
// (RULE2) reset clears all direction bits, pins inputs
// (RULE3) output pin: data read returns latch
// (RULE4) input pin: data read returns pin level
// (RULE5) data writes always update latch
// (RULE6) led enable selects 15 mA sink drive
// (RULE7) led drive only on output pins, per pin
// (RULE8) second port latches unaffected by reset
// (RULE9) two-wire enable takes second port pins 0,1
// (RULE10) serial enable takes second port pins 2,3
// (RULE11) timer select takes second port pins 4-7
// (RULE12) second port pins 0-3 only sink or release
// (RULE13) software writes data before setting direction
// (RULE14) unselected first port pins stay digital io
// (RULE15) converter channel select overrides first port pin
// (RULE16) first port latches unaffected by reset
// (RULE17) direction and led registers read back written
module dpgl_port
    import dpgl_pkg::*;
(
    input wire logic pclk, // system clock, 40 MHz
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [ADDR_W-1:0] paddr, // apb byte address
    input wire logic [DATA_W-1:0] pwdata, // apb write data
    output logic [DATA_W-1:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input wire logic [PORT_W-1:0] pa_in, // first port pin levels
    output logic [PORT_W-1:0] pa_out, // first port pin values
    output logic [PORT_W-1:0] pa_oe, // first port output enables
    output logic [PORT_W-1:0] pa_led_drive, // 15 mA sink selects
    output logic [PORT_W-1:0] pa_conv_sel, // pin routed to converter
    input wire logic [4:0] converter_channel_select, // converter channel
    input wire logic [PORT_W-1:0] pb_in, // second port pin levels
    output logic [PORT_W-1:0] pb_out, // second port pin values
    output logic [PORT_W-1:0] pb_oe, // second port output enables
    input wire logic twowire_module_enable, // two-wire owns pins 0,1
    input wire logic tw_data_low, // two-wire pulls data low
    input wire logic tw_clock_low, // two-wire pulls clock low
    output logic tw_data_in, // synced data pin to two-wire
    output logic tw_clock_in, // synced clock pin to two-wire
    input wire logic serial_module_enable, // serial owns pins 2,3
    input wire logic ser_txd, // serial transmit level
    output logic ser_rxd, // synced receive pin to serial
    input wire logic [7:0] timer_edge_level_select, // 2 bits/channel
    input wire logic [TIMER_CHANNELS-1:0] tim_ch_out, // compare level
    input wire logic [TIMER_CHANNELS-1:0] tim_ch_oe, // channel drives
    output logic [TIMER_CHANNELS-1:0] tim_ch_in // synced capture pins
);

    logic [PORT_W-1:0] pa_dir_reg;
    logic [PORT_W-1:0] pb_dir_reg;
    logic [PORT_W-1:0] pa_led_reg;
    logic [PORT_W-1:0] pa_data_reg;
    logic [PORT_W-1:0] pb_data_reg;
    logic [PORT_W-1:0] pa_meta_reg;
    logic [PORT_W-1:0] pa_sync_reg;
    logic [PORT_W-1:0] pb_meta_reg;
    logic [PORT_W-1:0] pb_sync_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic err_reg;
    logic [DATA_W-1:0] rdata_next;
    logic err_next;
    logic [PORT_W-1:0] pb_periph;
    logic [PORT_W-1:0] pb_periph_oe;
    logic [PORT_W-1:0] pb_periph_val;
    logic [TIMER_CHANNELS-1:0] tim_own;
    logic setup_phase;
    logic wr_take;

    // maps a byte address onto a register index; misaligned never hits
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] idx);
        hit = (a[1:0] == 2'h0) && (a[ADDR_W-1:2] == idx[ADDR_W-3:0]);
    endfunction

    // port value as software sees it: latch for outputs, pin for inputs
    function automatic logic [PORT_W-1:0] view(input logic [PORT_W-1:0] d,
                                               input logic [PORT_W-1:0] p,
                                               input logic [PORT_W-1:0] l);
        view = (d & l) | (~d & p);
    endfunction

    assign setup_phase = psel && !penable;
    assign wr_take = psel && penable && pwrite;

    // two-stage synchronisers on every pin input
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pa_meta_reg <= 8'h00;
            pa_sync_reg <= 8'h00;
            pb_meta_reg <= 8'h00;
            pb_sync_reg <= 8'h00;
        end else begin
            pa_meta_reg <= pa_in;
            pa_sync_reg <= pa_meta_reg;
            pb_meta_reg <= pb_in;
            pb_sync_reg <= pb_meta_reg;
        end
    end

    // control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pa_dir_reg <= DIR_RESET; // [RULE2]
            pb_dir_reg <= DIR_RESET; // [RULE2]
            pa_led_reg <= LED_RESET;
        end else if (wr_take) begin
            if (hit(paddr, IDX_FIRST_DIR))
                pa_dir_reg <= pwdata[PORT_W-1:0]; // [RULE17]
            if (hit(paddr, IDX_SECOND_DIR))
                pb_dir_reg <= pwdata[PORT_W-1:0]; // [RULE17]
            if (hit(paddr, IDX_FIRST_LED))
                pa_led_reg <= pwdata[PORT_W-1:0]; // [RULE17]
        end
    end

    // data latches carry no reset, so their contents survive it
    always_ff @(posedge pclk) begin
        if (wr_take && hit(paddr, IDX_FIRST_DATA))
            pa_data_reg <= pwdata[PORT_W-1:0]; // [RULE5] [RULE16]
        if (wr_take && hit(paddr, IDX_SECOND_DATA))
            pb_data_reg <= pwdata[PORT_W-1:0]; // [RULE5] [RULE8]
    end

    // read data is captured in the setup cycle and served in access
    always_comb begin
        rdata_next = '0;
        err_next = 1'b0;
        if (hit(paddr, IDX_FIRST_DATA))
            rdata_next[PORT_W-1:0] =
                view(pa_dir_reg & ~pa_conv_sel, pa_sync_reg & ~pa_conv_sel,
                     pa_data_reg); // [RULE3] [RULE4] [RULE14]
        else if (hit(paddr, IDX_SECOND_DATA))
            rdata_next[PORT_W-1:0] =
                view(pb_dir_reg, pb_sync_reg, pb_data_reg); // [RULE3] [RULE4]
        else if (hit(paddr, IDX_FIRST_DIR))
            rdata_next[PORT_W-1:0] = pa_dir_reg; // [RULE17]
        else if (hit(paddr, IDX_SECOND_DIR))
            rdata_next[PORT_W-1:0] = pb_dir_reg; // [RULE17]
        else if (hit(paddr, IDX_FIRST_LED))
            rdata_next[PORT_W-1:0] = pa_led_reg; // [RULE17]
        else
            err_next = 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_reg <= '0;
            err_reg <= 1'b0;
        end else if (setup_phase) begin
            rdata_reg <= pwrite ? '0 : rdata_next;
            err_reg <= err_next;
        end
    end

    // one wait-free access phase: every transfer ends in two cycles
    assign pready = psel && penable;
    assign prdata = rdata_reg;
    assign pslverr = psel && penable && err_reg;

    // first port: converter channel takes the pin away from the port
    genvar gi;
    generate
        for (gi = 0; gi < PORT_W; gi++) begin : g_first
            assign pa_conv_sel[gi] =
                (converter_channel_select == 5'(gi)); // [RULE15]
        end
    endgenerate

    assign pa_out = pa_data_reg;
    assign pa_oe = pa_dir_reg & ~pa_conv_sel; // [RULE1] [RULE14] [RULE15]
    // led sink only where the pin really drives
    assign pa_led_drive = pa_led_reg & pa_oe; // [RULE6] [RULE7]

    // second port peripheral ownership
    generate
        for (gi = 0; gi < TIMER_CHANNELS; gi++) begin : g_timer
            assign tim_own[gi] =
                (timer_edge_level_select[2*gi +: 2] != ELS_PORT); // [RULE11]
        end
    endgenerate

    assign pb_periph = {tim_own, {2{serial_module_enable}},
                        {2{twowire_module_enable}}}; // [RULE9] [RULE10]
    // peripheral drive requests; open-drain pins only pull low
    assign pb_periph_oe = {tim_ch_oe, 1'b0, !ser_txd,
                           tw_clock_low, tw_data_low}; // [RULE12]
    assign pb_periph_val = {tim_ch_out, 4'h0};

    generate
        for (gi = 0; gi < PORT_W; gi++) begin : g_second
            if (gi < OPEN_DRAIN_PINS) begin : g_od
                // pin is never driven high; the pullup supplies the one
                assign pb_out[gi] = 1'b0; // [RULE12]
                assign pb_oe[gi] = pb_periph[gi] ? pb_periph_oe[gi]
                    : (pb_dir_reg[gi] && !pb_data_reg[gi]); // [RULE1]
            end else begin : g_pp
                assign pb_out[gi] = pb_periph[gi] ? pb_periph_val[gi]
                    : pb_data_reg[gi]; // [RULE11]
                assign pb_oe[gi] = pb_periph[gi] ? pb_periph_oe[gi]
                    : pb_dir_reg[gi]; // [RULE1] [RULE11]
            end
        end
    endgenerate

    assign tw_data_in = pb_sync_reg[PIN_TW_DATA];
    assign tw_clock_in = pb_sync_reg[PIN_TW_CLOCK];
    assign ser_rxd = pb_sync_reg[PIN_SER_RX];
    assign tim_ch_in = pb_sync_reg[PORT_W-1:PIN_TIMER_LO];

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_dir_oe;
        (pa_oe & ~pa_dir_reg) == 8'h00;
    endproperty
    a_dir_oe: assert property (p_dir_oe) // [RULE1]
        else $error("first port drives a pin set as input");

    property p_reset_dir;
        $rose(presetn) |-> (pa_dir_reg == 8'h00) && (pb_dir_reg == 8'h00);
    endproperty
    a_reset_dir: assert property (@(posedge pclk) p_reset_dir) // [RULE2]
        else $error("direction not cleared by reset");

    property p_read_latch;
        (setup_phase && !pwrite && hit(paddr, IDX_SECOND_DATA)
            && pb_dir_reg == 8'hFF) ##1 (psel && penable)
            |-> prdata[PORT_W-1:0] == $past(pb_data_reg);
    endproperty
    a_read_latch: assert property (p_read_latch) // [RULE3]
        else $error("output pin read did not return latch");

    property p_read_pin;
        (setup_phase && !pwrite && hit(paddr, IDX_SECOND_DATA)
            && pb_dir_reg == 8'h00) |=>
            prdata[PORT_W-1:0] == $past(pb_sync_reg);
    endproperty
    a_read_pin: assert property (p_read_pin) // [RULE4]
        else $error("input pin read did not return pin level");

    property p_write_latch;
        (wr_take && hit(paddr, IDX_FIRST_DATA))
            |=> pa_data_reg == $past(pwdata[PORT_W-1:0]);
    endproperty
    a_write_latch: assert property (p_write_latch) // [RULE5]
        else $error("data write lost");

    property p_led_gate;
        (pa_led_drive & ~(pa_dir_reg & pa_led_reg)) == 8'h00;
    endproperty
    a_led_gate: assert property (p_led_gate) // [RULE7]
        else $error("led drive on a pin that is not an output");

    property p_twowire;
        twowire_module_enable |-> pb_oe[1:0] == {tw_clock_low, tw_data_low};
    endproperty
    a_twowire: assert property (p_twowire) // [RULE9]
        else $error("two-wire pins not under module control");

    property p_serial;
        serial_module_enable |-> !pb_oe[PIN_SER_RX]
            && pb_oe[PIN_SER_TX] == !ser_txd;
    endproperty
    a_serial: assert property (p_serial) // [RULE10]
        else $error("serial pins not under module control");

    property p_open_drain;
        pb_out[3:0] == 4'h0;
    endproperty
    a_open_drain: assert property (p_open_drain) // [RULE12]
        else $error("open-drain pin driven high");

    property p_conv;
        (converter_channel_select <= CONV_LAST_PIN)
            |-> !pa_oe[converter_channel_select[2:0]];
    endproperty
    a_conv: assert property (p_conv) // [RULE15]
        else $error("converter pin still driven by port");

    property p_dir_readback;
        (wr_take && hit(paddr, IDX_FIRST_DIR)) ##1
            (setup_phase && !pwrite && hit(paddr, IDX_FIRST_DIR))
            |=> prdata[PORT_W-1:0] == $past(pwdata[PORT_W-1:0], 2);
    endproperty
    a_dir_readback: assert property (p_dir_readback) // [RULE17]
        else $error("direction register readback wrong");

endmodule // dpgl_port

// ===== dpgl_pins.sv
// pin model: external levels, pull-ups on the open-drain pins
`timescale 1ns/1ps
module dpgl_pins
    import dpgl_pkg::*;
(
    input wire logic [PORT_W-1:0] pa_out, // first port drive values
    input wire logic [PORT_W-1:0] pa_oe, // first port drive enables
    input wire logic [PORT_W-1:0] pa_ext, // outside levels, first port
    input wire logic [PORT_W-1:0] pb_out, // second port drive values
    input wire logic [PORT_W-1:0] pb_oe, // second port drive enables
    input wire logic [PORT_W-1:0] pb_ext, // outside levels, second port
    output logic [PORT_W-1:0] pa_in, // first port pin levels
    output logic [PORT_W-1:0] pb_in // second port pin levels
);
    always_comb begin
        for (int i = 0; i < PORT_W; i++) begin
            pa_in[i] = pa_oe[i] ? pa_out[i] : pa_ext[i];
            pb_in[i] = pb_oe[i] ? pb_out[i] : pb_ext[i];
        end
        // enable sinks the pin; a released pin is pulled high
        for (int i = 0; i < OPEN_DRAIN_PINS; i++)
            pb_in[i] = ~pb_oe[i];
    end
endmodule // dpgl_pins

// ===== dpgl_port_tb.sv
// self-checking bench for the dual gpio port block
`timescale 1ns/1ps
module dpgl_port_tb;
    import dpgl_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00, pa_ext = 8'h00, pb_ext = 8'hF0;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, tw_data_in, tw_clock_in, ser_rxd;
    logic [7:0] pa_in, pa_out, pa_oe, pa_led_drive, pa_conv_sel;
    logic [7:0] pb_in, pb_out, pb_oe, timer_edge_level_select = 8'h00;
    logic [4:0] converter_channel_select = 5'h1F;
    logic twowire_module_enable = 0, tw_data_low = 0, tw_clock_low = 0;
    logic serial_module_enable = 0, ser_txd = 1;
    logic [3:0] tim_ch_out = 4'h0, tim_ch_oe = 4'h0, tim_ch_in;
    int errors = 0, tests_run = 0;
    dpgl_port i_dpgl_port (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .pa_in, .pa_out,
        .pa_oe, .pa_led_drive, .pa_conv_sel, .converter_channel_select,
        .pb_in, .pb_out, .pb_oe, .twowire_module_enable, .tw_data_low,
        .tw_clock_low, .tw_data_in, .tw_clock_in, .serial_module_enable,
        .ser_txd, .ser_rxd, .timer_edge_level_select, .tim_ch_out,
        .tim_ch_oe, .tim_ch_in);
    dpgl_pins i_dpgl_pins (.pa_out, .pa_oe, .pa_ext, .pb_out, .pb_oe,
        .pb_ext, .pa_in, .pb_in);
    initial forever #12.5 pclk = ~pclk;
    task automatic check(string nm, logic [31:0] got, logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // one apb transfer; waits for pready, no assumed latency
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        // ends on pready; only the watchdog may end it if pready never comes
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1, a, {24'h0, d}, r, e);
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] exp, string nm);
        logic [31:0] r;
        logic e;
        apb(0, a, 32'h0, r, e);
        check(nm, r, exp);
    endtask
    task automatic t_reset();
        rd(8'h10, 32'h00, "first dir reset");
        rd(8'h14, 32'h00, "second dir reset");
        rd(8'h30, 32'h00, "led reset");
        @(negedge pclk);
        check("oe after reset", {pa_oe, pb_oe}, 16'h0);
    endtask
    task automatic t_first();
        wr(8'h00, 8'hA5); // data before direction
        wr(8'h10, 8'hFF);
        @(negedge pclk);
        check("pa drive", {pa_oe, pa_out}, 16'hFFA5);
        rd(8'h00, 32'hA5, "latch read");
        pa_ext <= 8'h3C;
        wr(8'h10, 8'h0F);
        repeat (3) @(posedge pclk);
        rd(8'h00, 32'h35, "mixed read");
        wr(8'h00, 8'h00);
        rd(8'h00, 32'h30, "input keeps pin");
        wr(8'h10, 8'hFF);
        rd(8'h00, 32'h00, "latch took write");
        rd(8'h10, 32'hFF, "dir readback");
    endtask
    task automatic t_led();
        wr(8'h10, 8'h0F);
        wr(8'h30, 8'hFF);
        @(negedge pclk);
        check("led only outputs", pa_led_drive, 8'h0F);
        rd(8'h30, 32'hFF, "led readback");
        wr(8'h30, 8'h05);
        @(negedge pclk);
        check("led per pin", pa_led_drive, 8'h05);
    endtask
    // write then read with no idle cycle: psel stays high between them
    task automatic t_back_to_back();
        @(posedge pclk);
        psel <= 1; pwrite <= 1; paddr <= 8'h10; pwdata <= 32'h5A;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        penable <= 0; pwrite <= 0; pwdata <= 32'h0;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        check("dir back to back", prdata, 32'h5A);
        psel <= 0; penable <= 0;
    endtask
    task automatic t_conv();
        wr(8'h10, 8'hFF);
        converter_channel_select <= 5'h03;
        @(negedge pclk);
        check("conv pin", {pa_conv_sel, pa_oe}, 16'h08F7);
        @(posedge pclk);
        converter_channel_select <= 5'h10;
        @(negedge pclk);
        check("no conv pin", {pa_conv_sel, pa_oe}, 16'h00FF);
    endtask
    task automatic t_second();
        wr(8'h04, 8'h9A);
        wr(8'h14, 8'hFF);
        @(negedge pclk);
        check("open drain", {pb_oe, pb_out}, 16'hF590);
        rd(8'h04, 32'h9A, "second latch");
        twowire_module_enable <= 1; serial_module_enable <= 1;
        timer_edge_level_select <= 8'h01; tim_ch_out <= 4'h1;
        @(negedge pclk);
        check("takeover idle", pb_oe, 8'hE0);
        @(posedge pclk);
        tw_data_low <= 1; ser_txd <= 0; tim_ch_oe <= 4'h1;
        tim_ch_out <= 4'h0;
        @(negedge pclk);
        check("takeover drive", {pb_oe, pb_out}, 16'hF580);
        repeat (3) @(posedge pclk);
        check("peripheral ins", {tw_data_in, tw_clock_in, ser_rxd,
              tim_ch_in[0]}, 4'h6);
        twowire_module_enable <= 0; serial_module_enable <= 0;
        timer_edge_level_select <= 8'h00;
    endtask
    task automatic t_bad_and_reset();
        logic [31:0] r;
        logic e;
        apb(0, 8'h08, 32'h0, r, e);
        check("unmapped error", {31'h0, e}, 32'h1);
        check("unmapped data", r, 32'h0);
        wr(8'h00, 8'h5C);
        wr(8'h04, 8'h3E);
        @(posedge pclk);
        presetn <= 0;
        repeat (2) @(posedge pclk);
        presetn <= 1;
        rd(8'h14, 32'h00, "dir cleared again");
        rd(8'h04, 32'hFF, "second pins read");
        wr(8'h10, 8'hFF);
        wr(8'h14, 8'hFF);
        rd(8'h00, 32'h5C, "first latch kept");
        rd(8'h04, 32'h3E, "second latch kept");
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1;
        t_reset();
        t_first();
        t_led();
        t_back_to_back();
        t_conv();
        t_second();
        t_bad_and_reset();
        finish_test();
    end
    // whole run needs under two hundred cycles
    initial begin
        repeat (20000) @(posedge pclk);
        errors++;
        finish_test();
    end
endmodule // dpgl_port_tb
